// file: rtl/irq_boot_pkg.sv
/*
  Shared constants and types for the reset, boot-mode and external interrupt block.
  Assumes a single 10 MHz clock and an active-low asynchronous block reset.
*/
package irq_boot_pkg;

  // register indices on the plain register port
  localparam logic [3:0] REG_IRQ_FLAG   = 4'h0;
  localparam logic [3:0] REG_IRQ_MASK   = 4'h1;
  localparam logic [3:0] REG_GLOBAL     = 4'h2;
  localparam logic [3:0] REG_PROCESSOR_MODE_STATUS_REG       = 4'h3;
  localparam logic [3:0] REG_PIN_STATUS = 4'h4;
  localparam logic [3:0] REG_EVT_STATUS = 4'h5;
  localparam logic [3:0] REG_EVT_MASK   = 4'h6;
  localparam logic [3:0] REG_STATE      = 4'h7;

  // reset values
  localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;
  localparam logic        GLOBAL_RST    = 1'b1;
  localparam logic [2:0]  EVT_MASK_RST  = 3'h0;

  // event status bit positions
  localparam int EV_NMI  = 0;
  localparam int EV_BOOT = 1;
  localparam int EV_ACK  = 2;

  // vector table: reset vector, then one slot per source, four words apart
  localparam logic [15:0] RESET_VECTOR = 16'hff80;
  localparam logic [2:0]  VEC_IDX_NMI  = 3'h1;
  localparam logic [2:0]  VEC_IDX_EXT_IRQ0_IN = 3'h2;
  localparam int          VEC_SHIFT    = 2;

  // internal ROM occupies the upper 16K words of program space
  localparam logic [15:0] ROM_BASE = 16'hc000;

  // cycles the acknowledge stands while the vector is fetched
  localparam logic [1:0] ACK_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_BOOT  = 2'b01,
    ST_RUN   = 2'b11,
    ST_ACK   = 2'b10
  } cpu_state_t;

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_t;

endpackage

// file: rtl/pin_sync.sv
/*
  Two-flip-flop synchroniser for one asynchronous pin.
  Assumes the pin may change at any time relative to ref_clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic ref_clk_in, // block clock
  input  wire logic nrst_in,    // async reset, active low
  input  wire logic pin_in,     // raw pin
  output logic      sync_out    // synchronised level
);

  irq_boot_pkg::sync_state_t s_q;
  irq_boot_pkg::sync_state_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.meta   = pin_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '{meta: RESET_VAL, stable: RESET_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;

endmodule
`default_nettype wire

// file: rtl/prio_pick.sv
/*
  Fixed-priority picker: the lowest-numbered request wins.
  Purely combinational; assumes N is at least two.
*/
`timescale 1ns/1ps
`default_nettype none
module prio_pick #(
  parameter int N  = 4,
  parameter int IW = 2
) (
  input  wire logic [N-1:0]  req_in,   // pending and enabled requests
  output logic               valid_out, // any request present
  output logic [IW-1:0]      idx_out    // index of the winner
);

  always_comb begin
    valid_out = 1'b0;
    idx_out   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_in[i]) begin
        valid_out = 1'b1;
        idx_out   = IW'(i);
      end
    end
  end

endmodule
`default_nettype wire

// file: rtl/interrupt_reset_boot_pins.sv
/*
  Reset, boot-mode and external interrupt logic of the DSP core as seen at its pins.
  Holds flag, mask, mode and event registers on a plain register port, sequences reset
  release to the reset vector and acknowledges accepted interrupts with the vector on
  the low address lines. Assumes all pins are asynchronous to ref_clk_in and that the
  CPU core signals on cpu_ready_in when it may take an interrupt.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - acknowledge drives low while the vector is fetched, vector on low sixteen address lines
// - acknowledge pin floats whenever the output-disable pin is low
// - four maskable inputs are prioritised, gated by their mask bit and global bit
// - flag register and pin status show the four maskable inputs for polling
// - non-maskable input is taken regardless of global bit and mask register
// - non-maskable request branches to its own vector slot
// - reset pin low halts execution and re-initialises core and peripherals
// - reset pin release starts fetching at the fixed reset vector
// - rom-map pin low at reset maps internal ROM into upper 16K words
// - rom-map pin high at reset removes internal ROM from program space
// - rom-map pin is sampled only while reset is held
// - software may override the reset-chosen ROM mode through the mode register
module interrupt_reset_boot_pins (
  input  wire logic        ref_clk_in,        // 10 MHz block clock
  input  wire logic        nrst_in,           // async block reset, active low
  input  wire logic        reset_in_n,        // reset pin, active low
  input  wire logic        rom_map_select,    // rom-map select pin
  input  wire logic        ext_irq0_in,       // external interrupt 0, active low
  input  wire logic        ext_irq1_in,       // external interrupt 1, active low
  input  wire logic        ext_irq2_in,       // external interrupt 2, active low
  input  wire logic        ext_irq3_in,       // external interrupt 3, active low
  input  wire logic        nmi_n_in,          // non-maskable interrupt, active low
  input  wire logic        out_disable_n_in,  // output-disable pin, active low
  input  wire logic        cpu_ready_in,      // core may take an interrupt now
  input  wire logic [3:0]  reg_addr_in,       // register index
  input  wire logic [15:0] reg_wdata_in,      // register write data
  input  wire logic        reg_wr_in,         // write strobe
  input  wire logic        reg_rd_in,         // read strobe
  output logic      [15:0] reg_rdata_out,     // read data, cycle after strobe
  output logic             interrupt_ack_out, // acknowledge pin level, active low
  output logic             interrupt_ack_oe_out, // acknowledge pin drive enable
  output logic      [15:0] addr_out,          // low address lines during vector fetch
  output logic             addr_oe_out,       // address drive enable
  output logic             cpu_run_out,       // core may execute
  output logic             periph_init_out,   // peripherals held in initialisation
  output logic             pc_load_out,       // one-cycle program counter load
  output logic      [15:0] pc_vector_out,     // value for the program counter
  output logic             rom_mapped_out,    // internal ROM visible in program space
  output logic      [15:0] rom_base_out,      // first word of the ROM window
  output logic             irq_out            // level interrupt to the host
);

  typedef struct packed {
    irq_boot_pkg::cpu_state_t st;
    logic [3:0]  irq_flag_reg;
    logic [3:0]  irq_mask_reg;
    logic        global_irq_mask_bit;
    logic        processor_mode_status_reg;
    logic [2:0]  evt_status;
    logic [2:0]  evt_mask;
    logic [3:0]  irq_prev;
    logic        nmi_prev;
    logic        nmi_pend;
    logic [1:0]  ack_cnt;
    logic [15:0] vec;
    logic        pc_load;
    logic [15:0] rdata;
  } core_state_t;

  core_state_t s_q;
  core_state_t s_d;

  logic [7:0] raw_pins;
  logic [7:0] sync_pins;
  logic [3:0] irq_lvl_n;
  logic       nmi_lvl_n;
  logic       rs_n;
  logic       map_sel;
  logic       off_n;
  logic [3:0] irq_fall;
  logic       nmi_fall;
  logic [3:0] irq_enabled;
  logic       pick_valid;
  logic [1:0] pick_idx;
  logic       wr_flag;
  logic       wr_evt;
  logic [2:0] evt_set;
  logic       take_nmi;
  logic       take_int;

  assign raw_pins = {out_disable_n_in, rom_map_select, reset_in_n, nmi_n_in,
                     ext_irq3_in, ext_irq2_in, ext_irq1_in, ext_irq0_in};

  // every pin passes two flops before any logic looks at it
  for (genvar g = 0; g < 8; g++) begin : g_sync
    pin_sync #(
      .RESET_VAL (1'b1)
    ) u_sync (
      .ref_clk_in (ref_clk_in),
      .nrst_in    (nrst_in),
      .pin_in     (raw_pins[g]),
      .sync_out   (sync_pins[g])
    );
  end

  assign irq_lvl_n = sync_pins[3:0];
  assign nmi_lvl_n = sync_pins[4];
  assign rs_n      = sync_pins[5];
  assign map_sel   = sync_pins[6];
  assign off_n     = sync_pins[7];

  // requests are taken on the falling edge so a held-low line is not taken twice
  assign irq_fall = s_q.irq_prev & ~irq_lvl_n;
  assign nmi_fall = s_q.nmi_prev & ~nmi_lvl_n;

  assign irq_enabled = s_q.irq_flag_reg & s_q.irq_mask_reg & {4{~s_q.global_irq_mask_bit}};

  prio_pick #(
    .N  (4),
    .IW (2)
  ) u_pick (
    .req_in    (irq_enabled),
    .valid_out (pick_valid),
    .idx_out   (pick_idx)
  );

  assign wr_flag  = reg_wr_in && (reg_addr_in == irq_boot_pkg::REG_IRQ_FLAG);
  assign wr_evt   = reg_wr_in && (reg_addr_in == irq_boot_pkg::REG_EVT_STATUS);
  assign take_nmi = (s_q.st == irq_boot_pkg::ST_RUN) && cpu_ready_in && s_q.nmi_pend;
  assign take_int = (s_q.st == irq_boot_pkg::ST_RUN) && cpu_ready_in && !s_q.nmi_pend && pick_valid;

  always_comb begin
    s_d          = s_q;
    s_d.pc_load  = 1'b0;
    s_d.irq_prev = irq_lvl_n;
    s_d.nmi_prev = nmi_lvl_n;
    evt_set      = 3'h0;

    // software writes; hardware sets below take precedence over clears
    if (reg_wr_in) begin
      case (reg_addr_in)
        irq_boot_pkg::REG_IRQ_FLAG: begin
          s_d.irq_flag_reg = s_q.irq_flag_reg & ~reg_wdata_in[3:0];
        end
        irq_boot_pkg::REG_IRQ_MASK: begin
          s_d.irq_mask_reg = reg_wdata_in[3:0];
        end
        irq_boot_pkg::REG_GLOBAL: begin
          s_d.global_irq_mask_bit = reg_wdata_in[0];
        end
        irq_boot_pkg::REG_PROCESSOR_MODE_STATUS_REG: begin
          s_d.processor_mode_status_reg = reg_wdata_in[0];
        end
        irq_boot_pkg::REG_EVT_STATUS: begin
          s_d.evt_status = s_q.evt_status & ~reg_wdata_in[2:0];
        end
        irq_boot_pkg::REG_EVT_MASK: begin
          s_d.evt_mask = reg_wdata_in[2:0];
        end
        default: begin
        end
      endcase
    end

    case (s_q.st)
      irq_boot_pkg::ST_RESET: begin
        if (rs_n) begin
          s_d.st = irq_boot_pkg::ST_BOOT;
        end
      end
      irq_boot_pkg::ST_BOOT: begin
        s_d.st      = irq_boot_pkg::ST_RUN;
        s_d.pc_load = 1'b1;
        s_d.vec     = irq_boot_pkg::RESET_VECTOR;
        evt_set[irq_boot_pkg::EV_BOOT] = 1'b1;
      end
      irq_boot_pkg::ST_RUN: begin
        if (take_nmi) begin
          s_d.st       = irq_boot_pkg::ST_ACK;
          s_d.pc_load  = 1'b1;
          s_d.ack_cnt  = irq_boot_pkg::ACK_CYCLES;
          s_d.nmi_pend = 1'b0;
          s_d.vec      = irq_boot_pkg::RESET_VECTOR +
                         16'({irq_boot_pkg::VEC_IDX_NMI, 2'b00});
          evt_set[irq_boot_pkg::EV_NMI] = 1'b1;
        end else if (take_int) begin
          s_d.st                      = irq_boot_pkg::ST_ACK;
          s_d.pc_load                 = 1'b1;
          s_d.ack_cnt                 = irq_boot_pkg::ACK_CYCLES;
          s_d.irq_flag_reg[pick_idx]  = 1'b0;
          // further maskable requests wait until software reopens the global gate
          s_d.global_irq_mask_bit     = 1'b1;
          s_d.vec                     = irq_boot_pkg::RESET_VECTOR +
                                        16'({irq_boot_pkg::VEC_IDX_EXT_IRQ0_IN + {1'b0, pick_idx}, 2'b00});
        end
      end
      irq_boot_pkg::ST_ACK: begin
        s_d.ack_cnt = s_q.ack_cnt - 2'h1;
        if (s_q.ack_cnt == 2'h1) begin
          s_d.st = irq_boot_pkg::ST_RUN;
          evt_set[irq_boot_pkg::EV_ACK] = 1'b1;
        end
      end
      default: begin
        s_d.st = irq_boot_pkg::ST_RESET;
      end
    endcase

    // hardware sets after software clears, so a same-cycle event is kept
    s_d.irq_flag_reg = s_d.irq_flag_reg | irq_fall;
    if (nmi_fall) begin
      s_d.nmi_pend = 1'b1;
    end
    s_d.evt_status = s_d.evt_status | evt_set;

    // reset pin: halt, re-initialise, and capture the rom-map pin while held
    if (!rs_n) begin
      s_d.st                        = irq_boot_pkg::ST_RESET;
      s_d.irq_flag_reg              = 4'h0;
      s_d.irq_mask_reg              = irq_boot_pkg::IRQ_MASK_RST;
      s_d.global_irq_mask_bit       = irq_boot_pkg::GLOBAL_RST;
      s_d.nmi_pend                  = 1'b0;
      s_d.ack_cnt                   = 2'h0;
      s_d.processor_mode_status_reg = map_sel;
    end

    s_d.rdata = 16'h0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        irq_boot_pkg::REG_IRQ_FLAG:   s_d.rdata = {12'h000, s_q.irq_flag_reg};
        irq_boot_pkg::REG_IRQ_MASK:   s_d.rdata = {12'h000, s_q.irq_mask_reg};
        irq_boot_pkg::REG_GLOBAL:     s_d.rdata = {15'h0000, s_q.global_irq_mask_bit};
        irq_boot_pkg::REG_PROCESSOR_MODE_STATUS_REG:       s_d.rdata = {15'h0000, s_q.processor_mode_status_reg};
        irq_boot_pkg::REG_PIN_STATUS: s_d.rdata = {11'h000, ~nmi_lvl_n, ~irq_lvl_n};
        irq_boot_pkg::REG_EVT_STATUS: s_d.rdata = {13'h0000, s_q.evt_status};
        irq_boot_pkg::REG_EVT_MASK:   s_d.rdata = {13'h0000, s_q.evt_mask};
        irq_boot_pkg::REG_STATE:      s_d.rdata = {13'h0000, s_q.nmi_pend, s_q.st};
        default:                      s_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '{st:                        irq_boot_pkg::ST_RESET,
               irq_flag_reg:              4'h0,
               irq_mask_reg:              irq_boot_pkg::IRQ_MASK_RST,
               global_irq_mask_bit:       irq_boot_pkg::GLOBAL_RST,
               processor_mode_status_reg: 1'b0,
               evt_status:                3'h0,
               evt_mask:                  irq_boot_pkg::EVT_MASK_RST,
               irq_prev:                  4'hf,
               nmi_prev:                  1'b1,
               nmi_pend:                  1'b0,
               ack_cnt:                   2'h0,
               vec:                       irq_boot_pkg::RESET_VECTOR,
               pc_load:                   1'b0,
               rdata:                     16'h0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out        = s_q.rdata;
  assign interrupt_ack_out    = ~(s_q.st == irq_boot_pkg::ST_ACK);
  assign interrupt_ack_oe_out = off_n;
  assign addr_out             = s_q.vec;
  assign addr_oe_out          = (s_q.st == irq_boot_pkg::ST_ACK) && off_n;
  assign cpu_run_out          = (s_q.st == irq_boot_pkg::ST_RUN) || (s_q.st == irq_boot_pkg::ST_ACK);
  assign periph_init_out      = (s_q.st == irq_boot_pkg::ST_RESET);
  assign pc_load_out          = s_q.pc_load;
  assign pc_vector_out        = s_q.vec;
  assign rom_mapped_out       = ~s_q.processor_mode_status_reg;
  assign rom_base_out         = irq_boot_pkg::ROM_BASE;
  assign irq_out              = |(s_q.evt_status & s_q.evt_mask);

endmodule
`default_nettype wire

// file: sim/irq_pin_source.sv
/*
  Far-side model: reset circuitry and external interrupt sources driving the pins.
  Assumes the bench calls its tasks; pins change right after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_pin_source (
  input  wire logic       ref_clk_in, // block clock
  output var  logic       rst_n_out,  // reset pin, active low
  output var  logic       rom_out,    // rom-map pin
  output var  logic [3:0] irq_n_out,  // maskable pins, active low
  output var  logic       nmi_n_out   // nmi pin, active low
);
  initial begin
    rst_n_out = 1'b0;
    rom_out = 1'b0;
    irq_n_out = 4'hf;
    nmi_n_out = 1'b1;
  end
  // lines are pulled up when released, so idle shows high
  task pulse(input int k);
    @(posedge ref_clk_in);
    if (k < 4) irq_n_out[k] <= 1'b0;
    else nmi_n_out <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    irq_n_out <= 4'hf;
    nmi_n_out <= 1'b1;
  endtask
  task set_rom(input logic v);
    @(posedge ref_clk_in);
    rom_out <= v;
  endtask
  task hold_reset(input logic rom);
    @(posedge ref_clk_in);
    rst_n_out <= 1'b0;
    rom_out <= rom;
    repeat (6) @(posedge ref_clk_in);
    rst_n_out <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
  endtask
endmodule
`default_nettype wire

// file: sim/interrupt_reset_boot_pins_sva.sv
/*
  Pin-level checker for the reset, boot-mode and interrupt block.
  Assumes it is bound to the block's top module.
*/
`timescale 1ns/1ps
`default_nettype none
module interrupt_reset_boot_pins_sva (
  input wire logic        ref_clk_in,           // clock
  input wire logic        nrst_in,              // block reset
  input wire logic        reset_in_n,           // reset pin
  input wire logic        rom_map_select,       // rom-map pin
  input wire logic        nmi_n_in,             // nmi pin
  input wire logic        out_disable_n_in,     // output-disable pin
  input wire logic        cpu_ready_in,         // core ready
  input wire logic        reg_wr_in,            // write strobe
  input wire logic        interrupt_ack_out,    // acknowledge
  input wire logic        interrupt_ack_oe_out, // acknowledge drive
  input wire logic [15:0] addr_out,             // vector address
  input wire logic        addr_oe_out,          // address drive
  input wire logic        cpu_run_out,          // core running
  input wire logic        periph_init_out,      // peripherals held
  input wire logic        pc_load_out,          // pc load
  input wire logic [15:0] pc_vector_out,        // pc value
  input wire logic        rom_mapped_out,       // rom mapped
  input wire logic [15:0] rom_base_out          // rom window base
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_ack_start; $fell(interrupt_ack_out); endsequence
  sequence s_boot_leave; $fell(periph_init_out); endsequence
  sequence s_boot_jump; ##1 (pc_load_out && cpu_run_out && pc_vector_out == 16'hff80); endsequence
  AST_ACK_ADDR: assert property (!interrupt_ack_out |-> addr_oe_out == interrupt_ack_oe_out)
    else $error("address drive differs from acknowledge drive");
  AST_ACK_LEN: assert property (s_ack_start |-> ##1 !interrupt_ack_out ##1 interrupt_ack_out)
    else $error("acknowledge length wrong");
  AST_ACK_VEC: assert property (s_ack_start |-> pc_load_out && addr_out == pc_vector_out
    && addr_out[15:5] == 11'h7fc && addr_out[1:0] == 2'h0 && addr_out[4:2] inside {[1:5]})
    else $error("vector fetch address wrong");
  AST_OFF_FLOAT: assert property (!out_disable_n_in [*3] |-> !interrupt_ack_oe_out && !addr_oe_out)
    else $error("pins driven while disabled");
  AST_HALT: assert property (!reset_in_n [*4] |-> periph_init_out && !cpu_run_out)
    else $error("core runs while reset pin low");
  AST_BOOT_VEC: assert property (s_boot_leave |-> s_boot_jump)
    else $error("no jump to reset vector");
  AST_ROM_SEL: assert property ((periph_init_out && $stable(rom_map_select)) [*4]
    |-> rom_mapped_out == !rom_map_select && rom_base_out == 16'hc000)
    else $error("rom mapping does not follow pin at reset");
  AST_ROM_HOLD: assert property (cpu_run_out && $past(cpu_run_out) && !$past(reg_wr_in)
    |-> $stable(rom_mapped_out))
    else $error("rom mapping changed without a write");
  AST_NMI_TAKE: assert property ($fell(nmi_n_in) && cpu_run_out && cpu_ready_in
    |-> ##[1:8] (!interrupt_ack_out || !cpu_run_out))
    else $error("nmi not taken");
endmodule
`default_nettype wire

// file: sim/interrupt_reset_boot_pins_bench.sv
/*
  Self-checking bench for the reset, boot-mode and interrupt block.
  Assumes the pin source model and the checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module interrupt_reset_boot_pins_bench;
  logic        ref_clk_in = 1'b0, nrst_in = 1'b0, off_n = 1'b1, cpu_ready_in = 1'b1;
  logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [15:0] reg_wdata_in = 16'h0, v;
  wire  logic  reset_in_n, rom_map_select, nmi_n;
  wire  logic  [3:0] irq_n;
  logic [15:0] rdata, addr_o, pcv, rbase;
  logic        ack, ack_oe, addr_oe, run, init, pcl, mapped, irq;
  int          n_fail = 0, n_compared = 0, cyc = 0;
  always #50 ref_clk_in = ~ref_clk_in;
  irq_pin_source src (.ref_clk_in, .rst_n_out(reset_in_n), .rom_out(rom_map_select), .irq_n_out(irq_n),
    .nmi_n_out(nmi_n));
  interrupt_reset_boot_pins DUT (.ref_clk_in, .nrst_in, .reset_in_n, .rom_map_select, .ext_irq0_in(irq_n[0]),
    .ext_irq1_in(irq_n[1]), .ext_irq2_in(irq_n[2]), .ext_irq3_in(irq_n[3]), .nmi_n_in(nmi_n),
    .out_disable_n_in(off_n), .cpu_ready_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out(rdata), .interrupt_ack_out(ack), .interrupt_ack_oe_out(ack_oe), .addr_out(addr_o),
    .addr_oe_out(addr_oe), .cpu_run_out(run), .periph_init_out(init), .pc_load_out(pcl),
    .pc_vector_out(pcv), .rom_mapped_out(mapped), .rom_base_out(rbase), .irq_out(irq));
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      close_out;
    end
  end
  task chk(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1; reg_addr_in <= a; reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1; reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(nm, rdata, e);
  endtask
  task wait_ack(output logic [15:0] a);
    int i;
    i = 0;
    do begin @(posedge ref_clk_in); #1; i++; end while (ack !== 1'b0 && i < 20);
    a = addr_o;
  endtask
  task t_boot;
    src.hold_reset(1'b0);
    #1 chk("mapped", mapped, 16'h1);
    chk("held init", init, 16'h0);
    chk("running", run, 16'h1);
    chk("boot vec", pcv, 16'hff80);
    chk("rom base", rbase, 16'hc000);
    rd(4'h7, 16'h0003, "state");
    rd(4'h5, 16'h0002, "evt");
    rd(4'h1, 16'h0000, "mask");
    rd(4'h2, 16'h0001, "global");
    rd(4'h9, 16'h0000, "unmapped");
    chk("irq masked", irq, 16'h0);
    wr(4'h6, 16'h2);
    chk("irq raised", irq, 16'h1);
    wr(4'h5, 16'h2);
    chk("irq cleared", irq, 16'h0);
    $display("test boot done");
  endtask
  task t_rom;
    wr(4'h3, 16'h1);
    chk("override", mapped, 16'h0);
    src.set_rom(1'b1);
    src.set_rom(1'b0);
    repeat (4) @(posedge ref_clk_in);
    #1 chk("pin ignored", mapped, 16'h0);
    src.hold_reset(1'b1);
    #1 chk("removed", mapped, 16'h0);
    rd(4'h3, 16'h0001, "mode");
    wr(4'h3, 16'h0);
    chk("remap", mapped, 16'h1);
    $display("test rom done");
  endtask
  task t_poll;
    for (int k = 0; k < 4; k++) begin
      src.pulse(k);
      rd(4'h0, 16'h1 << k, "flag");
      chk("no ack", ack, 16'h1);
      wr(4'h0, 16'h1 << k);
      rd(4'h0, 16'h0, "flag clear");
    end
    $display("test poll done");
  endtask
  task t_prio;
    src.pulse(2);
    src.pulse(1);
    wr(4'h1, 16'hf);
    repeat (4) @(posedge ref_clk_in);
    #1 chk("global holds", ack, 16'h1);
    wr(4'h2, 16'h0);
    wait_ack(v);
    chk("first vec", v, 16'hff8c);
    repeat (4) @(posedge ref_clk_in);
    rd(4'h0, 16'h0004, "left");
    rd(4'h2, 16'h0001, "global set");
    wr(4'h1, 16'h3);
    wr(4'h2, 16'h0);
    repeat (6) @(posedge ref_clk_in);
    #1 chk("mask holds", ack, 16'h1);
    wr(4'h1, 16'hf);
    wait_ack(v);
    chk("second vec", v, 16'hff90);
    $display("test prio done");
  endtask
  // core not ready: a flagged, enabled request must wait for it
  task t_ready;
    cpu_ready_in <= 1'b0;
    src.pulse(0);
    wr(4'h2, 16'h0);
    repeat (4) @(posedge ref_clk_in);
    #1 chk("ready holds", ack, 16'h1);
    cpu_ready_in <= 1'b1;
    wait_ack(v);
    chk("ext_irq0_in vec", v, 16'hff88);
    chk("pc load", pcl, 16'h1);
    chk("pc vec", pcv, 16'hff88);
    chk("addr drive", addr_oe, 16'h1);
    chk("ack drive", ack_oe, 16'h1);
    chk("run in ack", run, 16'h1);
    $display("test ready done");
  endtask
  task t_nmi;
    wr(4'h1, 16'h0);
    wr(4'h5, 16'h7);
    wr(4'h6, 16'h1);
    fork
      src.pulse(4);
      wait_ack(v);
    join
    chk("nmi vec", v, 16'hff84);
    // the acknowledge-done bit lands only as the two-cycle acknowledge ends
    repeat (2) @(posedge ref_clk_in);
    rd(4'h5, 16'h0005, "nmi evt");
    chk("nmi irq", irq, 16'h1);
    wr(4'h5, 16'h7);
    chk("nmi irq clr", irq, 16'h0);
    off_n <= 1'b0;
    fork
      src.pulse(4);
      wait_ack(v);
    join
    chk("ack float", ack_oe, 16'h0);
    chk("addr float", addr_oe, 16'h0);
    off_n <= 1'b1;
    $display("test nmi done");
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    t_boot;
    t_rom;
    t_poll;
    t_prio;
    t_ready;
    t_nmi;
    close_out;
  end
endmodule
bind interrupt_reset_boot_pins interrupt_reset_boot_pins_sva chk_i (.ref_clk_in, .nrst_in, .reset_in_n,
  .rom_map_select, .nmi_n_in, .out_disable_n_in, .cpu_ready_in, .reg_wr_in, .interrupt_ack_out,
  .interrupt_ack_oe_out, .addr_out, .addr_oe_out, .cpu_run_out, .periph_init_out, .pc_load_out,
  .pc_vector_out, .rom_mapped_out, .rom_base_out);
`default_nettype wire
